// ### src/pct_consts.svh
// Offsets, fields, reset values and interrupt identity of the private countdown timer
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH

// ==========================================
// Register offsets
`define PCT_OFF_RELOAD 8'h00
`define PCT_OFF_COUNT 8'h04
`define PCT_OFF_CTRL 8'h08
`define PCT_OFF_STATUS 8'h0c

// ==========================================
// Field positions
`define PCT_CTRL_EN_BIT 0
`define PCT_CTRL_AUTO_BIT 1
`define PCT_CTRL_IRQ_BIT 2
`define PCT_CTRL_PRE_LSB 8
`define PCT_CTRL_PRE_MSB 15
`define PCT_STATUS_EVT_BIT 0
`define PCT_CTRL_MASK 32'h0000ff07

// ==========================================
// Reset values and interrupt identity
`define PCT_RST_WORD 32'h00000000
`define PCT_IRQ_ID 8'h1d

`endif

// ### src/pct_pkg.sv
// Types shared by the private countdown timer
package pct_pkg;

  typedef struct packed {
    logic [7:0] prescale;
    logic irq_en;
    logic auto_reload;
    logic enable;
  } pct_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pct_req_t;

endpackage : pct_pkg

// ### src/pct_timer.sv
// Private countdown timer with prescaler, single-shot and auto-reload modes
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"

module pct_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Processor state
  input wire logic debug_halt,
  // Event outputs
  output logic zero_evt,
  output logic irq_pending
);

  pct_pkg::pct_req_t req;
  pct_pkg::pct_ctrl_t ctrl_ff;
  logic [31:0] reload_ff;
  logic [31:0] count_ff;
  logic [7:0] pre_cnt_ff;
  logic evt_ff;
  logic zero_evt_ff;
  logic irq_pending_ff;
  logic [31:0] rdata_ff;
  logic wr_reload;
  logic wr_count;
  logic wr_ctrl;
  logic wr_status;
  logic run;
  logic tick;
  logic hit_zero;
  logic [7:0] nxt_pre_cnt;
  logic [31:0] nxt_count;
  logic [31:0] nxt_rdata;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ==========================================
  // Address decode
  // Word-only access assumed; low address bits take part in decode
  assign wr_reload = req.wr && (req.addr == `PCT_OFF_RELOAD);
  assign wr_count = req.wr && (req.addr == `PCT_OFF_COUNT);
  assign wr_ctrl = req.wr && (req.addr == `PCT_OFF_CTRL);
  assign wr_status = req.wr && (req.addr == `PCT_OFF_STATUS);

  // ==========================================
  // Prescaler
  assign run = ctrl_ff.enable && !debug_halt;
  // Compare with >= so a prescaler lowered mid-interval ticks at once instead of wrapping through 256
  assign tick = run && (pre_cnt_ff >= ctrl_ff.prescale) && (count_ff != 32'h00000000);
  assign hit_zero = tick && (count_ff == 32'h00000001);

  always_comb begin
    nxt_pre_cnt = pre_cnt_ff;
    if (wr_reload || wr_count || tick) begin
      nxt_pre_cnt = 8'h00;
    end else if (run && (count_ff != 32'h00000000)) begin
      nxt_pre_cnt = pre_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt_ff <= 8'h00;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
    end
  end

  // ==========================================
  // Counter
  // Reload value of zero in auto mode simply parks the counter at zero
  always_comb begin
    nxt_count = count_ff;
    if (wr_reload || wr_count) begin
      nxt_count = req.wdata;
    end else if (hit_zero && ctrl_ff.auto_reload) begin
      nxt_count = reload_ff;
    end else if (tick) begin
      nxt_count = count_ff - 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= `PCT_RST_WORD;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ==========================================
  // Reload and control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_ff <= `PCT_RST_WORD;
    end else if (wr_reload) begin
      reload_ff <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff.enable <= req.wdata[`PCT_CTRL_EN_BIT];
      ctrl_ff.auto_reload <= req.wdata[`PCT_CTRL_AUTO_BIT];
      ctrl_ff.irq_en <= req.wdata[`PCT_CTRL_IRQ_BIT];
      ctrl_ff.prescale <= req.wdata[`PCT_CTRL_PRE_MSB:`PCT_CTRL_PRE_LSB];
    end
  end

  // ==========================================
  // Event flag and interrupt
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_ff <= 1'b0;
    end else if (hit_zero) begin
      evt_ff <= 1'b1;
    end else if (wr_status && req.wdata[`PCT_STATUS_EVT_BIT]) begin
      evt_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zero_evt_ff <= 1'b0;
      irq_pending_ff <= 1'b0;
    end else begin
      zero_evt_ff <= hit_zero;
      irq_pending_ff <= hit_zero && ctrl_ff.irq_en;
    end
  end

  assign zero_evt = zero_evt_ff;
  assign irq_pending = irq_pending_ff;

  // ==========================================
  // Read path
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (req.addr)
      `PCT_OFF_RELOAD: begin
        nxt_rdata = reload_ff;
      end
      `PCT_OFF_COUNT: begin
        nxt_rdata = count_ff;
      end
      `PCT_OFF_CTRL: begin
        nxt_rdata = {16'h0000, ctrl_ff.prescale, 5'h00, ctrl_ff.irq_en, ctrl_ff.auto_reload, ctrl_ff.enable};
      end
      `PCT_OFF_STATUS: begin
        nxt_rdata = {31'h00000000, evt_ff};
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign rdata = rdata_ff;

  // ==========================================
  // Checks
  property p_load_copies;
    @(posedge clk) disable iff (rst) wr_reload |=> (count_ff == $past(wdata)) && (reload_ff == $past(wdata));
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("load write did not reach counter");

  property p_count_write;
    @(posedge clk) disable iff (rst) (wr_count && !wr_reload) |=> count_ff == $past(wdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_hold_disabled;
    @(posedge clk) disable iff (rst) (!ctrl_ff.enable && !wr_count && !wr_reload) |=> $stable(count_ff);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("counter moved while disabled");

  property p_hold_debug;
    @(posedge clk) disable iff (rst) (debug_halt && !wr_count && !wr_reload) |=> $stable(count_ff);
  endproperty
  a_hold_debug: assert property (p_hold_debug) else $error("counter moved in debug");

  property p_evt_sets;
    @(posedge clk) disable iff (rst) hit_zero |=> evt_ff && zero_evt;
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("event flag not set at zero");

  property p_irq_gate;
    @(posedge clk) disable iff (rst) irq_pending |-> $past(ctrl_ff.irq_en) && zero_evt;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

  property p_evt_sticky;
    @(posedge clk) disable iff (rst) (evt_ff && !(wr_status && wdata[0])) |=> evt_ff;
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event flag dropped");

  property p_single_stop;
    @(posedge clk) disable iff (rst) (hit_zero && !ctrl_ff.auto_reload && !wr_count && !wr_reload)
      |=> (count_ff == 32'h00000000) ##1 !hit_zero;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single-shot did not stop");

  property p_auto_reload;
    @(posedge clk) disable iff (rst) (hit_zero && ctrl_ff.auto_reload && !wr_count && !wr_reload)
      |=> count_ff == $past(reload_ff);
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("auto reload missed");

  property p_pre_spacing;
    @(posedge clk) disable iff (rst) (tick && ctrl_ff.prescale == 8'h01 && !wr_ctrl) |=> !tick;
  endproperty
  a_pre_spacing: assert property (p_pre_spacing) else $error("prescaler ticked too soon");

  // ==========================================
  // Read port checks
  property p_rdata_idle;
    @(posedge clk) disable iff (rst) !rd |=> rdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_rd_reserved;
    @(posedge clk) disable iff (rst) (rd && (addr != `PCT_OFF_RELOAD) && (addr != `PCT_OFF_COUNT)
      && (addr != `PCT_OFF_CTRL) && (addr != `PCT_OFF_STATUS)) |=> rdata == 32'h00000000;
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved offset read nonzero");

  property p_rd_count;
    @(posedge clk) disable iff (rst) (rd && addr == `PCT_OFF_COUNT) |=> rdata == $past(count_ff);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count read wrong");

  property p_rd_reload;
    @(posedge clk) disable iff (rst) (rd && addr == `PCT_OFF_RELOAD) |=> rdata == $past(reload_ff);
  endproperty
  a_rd_reload: assert property (p_rd_reload) else $error("reload read wrong");

  property p_rd_status;
    @(posedge clk) disable iff (rst) (rd && addr == `PCT_OFF_STATUS) |=> rdata == {31'h00000000, $past(evt_ff)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");

  property p_rd_ctrl_mask;
    @(posedge clk) disable iff (rst) (rd && addr == `PCT_OFF_CTRL) |=> (rdata & ~`PCT_CTRL_MASK) == 32'h00000000;
  endproperty
  a_rd_ctrl_mask: assert property (p_rd_ctrl_mask) else $error("unused control bits read nonzero");

  // ==========================================
  // Register write and reset checks
  property p_ctrl_write;
    @(posedge clk) disable iff (rst) wr_ctrl |=> ctrl_ff.enable == $past(wdata[`PCT_CTRL_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable bit not written");

  property p_ctrl_pre_write;
    @(posedge clk) disable iff (rst) wr_ctrl |=> ctrl_ff.prescale == $past(wdata[`PCT_CTRL_PRE_MSB:`PCT_CTRL_PRE_LSB]);
  endproperty
  a_ctrl_pre_write: assert property (p_ctrl_pre_write) else $error("prescaler not written");

  property p_reserved_write_ignored;
    @(posedge clk) disable iff (rst) (wr && !wr_reload && !wr_count && !wr_ctrl && !wr_status && !hit_zero)
      |=> $stable(reload_ff) && $stable(ctrl_ff) && $stable(evt_ff);
  endproperty
  a_reserved_write_ignored: assert property (p_reserved_write_ignored) else $error("reserved write had effect");

  property p_reset_clear;
    @(posedge clk) rst |=> (count_ff == 32'h00000000) && (reload_ff == 32'h00000000) && !evt_ff;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

  property p_ctrl_reset;
    @(posedge clk) rst |=> (ctrl_ff == '0) && (rdata == 32'h00000000) && !zero_evt && !irq_pending;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control or outputs not cleared by reset");

  // ==========================================
  // Counting checks
  property p_decrement_step;
    @(posedge clk) disable iff (rst) (tick && !hit_zero && !wr_count && !wr_reload)
      |=> count_ff == $past(count_ff) - 32'h00000001;
  endproperty
  a_decrement_step: assert property (p_decrement_step) else $error("decrement step wrong");

  property p_pre_restart;
    @(posedge clk) disable iff (rst) (wr_count || wr_reload) |=> pre_cnt_ff == 8'h00;
  endproperty
  a_pre_restart: assert property (p_pre_restart) else $error("prescaler not restarted on write");

  property p_pre_restart_tick;
    @(posedge clk) disable iff (rst) tick |=> pre_cnt_ff == 8'h00;
  endproperty
  a_pre_restart_tick: assert property (p_pre_restart_tick) else $error("prescaler not restarted on step");

  property p_pre_hold_debug;
    @(posedge clk) disable iff (rst) (debug_halt && !wr_count && !wr_reload) |=> $stable(pre_cnt_ff);
  endproperty
  a_pre_hold_debug: assert property (p_pre_hold_debug) else $error("prescaler moved in debug");

  property p_zero_rest;
    @(posedge clk) disable iff (rst) (count_ff == 32'h00000000 && !wr_count && !wr_reload) |=> count_ff == 32'h00000000;
  endproperty
  a_zero_rest: assert property (p_zero_rest) else $error("counter left zero without a write");

  property p_no_event_at_rest;
    @(posedge clk) disable iff (rst) count_ff == 32'h00000000 |-> !hit_zero;
  endproperty
  a_no_event_at_rest: assert property (p_no_event_at_rest) else $error("event from a resting counter");

  // ==========================================
  // Event and interrupt checks
  property p_zero_evt_src;
    @(posedge clk) disable iff (rst) zero_evt |-> $past(hit_zero);
  endproperty
  a_zero_evt_src: assert property (p_zero_evt_src) else $error("event pulse without reaching zero");

  property p_irq_follows;
    @(posedge clk) disable iff (rst) (hit_zero && ctrl_ff.irq_en) |=> irq_pending;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

  property p_no_irq_disabled;
    @(posedge clk) disable iff (rst) (hit_zero && !ctrl_ff.irq_en) |=> !irq_pending;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("interrupt raised while disabled");

  property p_evt_clear;
    @(posedge clk) disable iff (rst) (evt_ff && wr_status && wdata[`PCT_STATUS_EVT_BIT] && !hit_zero) |=> !evt_ff;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event flag not cleared");

  property p_evt_zero_write;
    @(posedge clk) disable iff (rst) (!evt_ff && wr_status && !hit_zero) |=> !evt_ff;
  endproperty
  a_evt_zero_write: assert property (p_evt_zero_write) else $error("status write set the flag");

endmodule : pct_timer
`default_nettype wire

// ### tb/tb_pct_timer.sv
// Self-checking bench for the private countdown timer
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"

module tb_pct_timer;
  // ==========================================
  // Signals
  localparam logic [7:0] A_LD = `PCT_OFF_RELOAD;
  localparam logic [7:0] A_CN = `PCT_OFF_COUNT;
  localparam logic [7:0] A_CT = `PCT_OFF_CTRL;
  localparam logic [7:0] A_ST = `PCT_OFF_STATUS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic debug_halt = 1'b0;
  logic [31:0] rdata;
  logic zero_evt;
  logic irq_pending;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int evt_n = 0;
  int irq_n = 0;
  int last_evt = 0;
  int prev_evt = 0;
  int e0;
  int i0;

  pct_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .debug_halt(debug_halt), .zero_evt(zero_evt), .irq_pending(irq_pending));

  always #25 clk = ~clk;

  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Whole-word accesses only
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Bounded wait so a missing event cannot hang the run
  task automatic wait_evt(input int n);
    int k;
    k = 0;
    while (evt_n < n && k < 200) begin
      @(posedge clk);
      k++;
    end
    #1;
  endtask : wait_evt

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Event monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (zero_evt === 1'b1) begin
      evt_n <= evt_n + 1;
      prev_evt <= last_evt;
      last_evt <= cyc;
    end
    if (irq_pending === 1'b1) begin
      irq_n <= irq_n + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(i * 4), 32'h00000000);
    end
    wr_reg(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'h00000000);
    wr_reg(A_CT, 32'hffffffff);
    rd_chk(A_CT, `PCT_CTRL_MASK);
    wr_reg(A_CT, 32'h00000000);
    wr_reg(A_LD, 32'h00000009);
    rd_chk(A_CN, 32'h00000009);
    repeat (20) @(posedge clk);
    rd_chk(A_CN, 32'h00000009);
    rd_chk(A_LD, 32'h00000009);
    // Enabled but frozen by debug state
    @(posedge clk);
    debug_halt <= 1'b1;
    wr_reg(A_CT, 32'h00000301);
    repeat (30) @(posedge clk);
    rd_chk(A_CN, 32'h00000009);
    @(posedge clk);
    debug_halt <= 1'b0;
    // Prescale 3: steps after 4, 8 and 12 cycles
    repeat (12) @(posedge clk);
    rd_chk(A_CN, 32'h00000006);
    check(32'(rdata < 32'h9), 32'h00000001);
    wr_reg(A_CN, 32'h00000064);
    rd_chk(A_CN, 32'h00000064);
    // Single-shot with interrupt
    wr_reg(A_ST, 32'h00000001);
    wr_reg(A_CT, 32'h00000205);
    e0 = evt_n;
    i0 = irq_n;
    wr_reg(A_LD, 32'h00000004);
    wait_evt(e0 + 1);
    repeat (40) @(posedge clk);
    check(32'(evt_n - e0), 32'h00000001);
    check(32'(irq_n - i0), 32'h00000001);
    rd_chk(A_CN, 32'h00000000);
    wr_reg(A_ST, 32'h00000000);
    rd_chk(A_ST, 32'h00000001);
    wr_reg(A_ST, 32'h00000001);
    rd_chk(A_ST, 32'h00000000);
    // Auto-reload, prescale 1, no interrupt: period is 5 * 2 cycles
    wr_reg(A_CT, 32'h00000103);
    e0 = evt_n;
    i0 = irq_n;
    wr_reg(A_LD, 32'h00000005);
    wait_evt(e0 + 2);
    check(32'(evt_n - e0), 32'h00000002);
    check(32'(last_evt - prev_evt), 32'h0000000a);
    check(32'(irq_n - i0), 32'h00000000);
    rd_chk(A_ST, 32'h00000001);
    // Writing zero raises no event
    wr_reg(A_CT, 32'h00000000);
    wr_reg(A_CN, 32'h00000000);
    wr_reg(A_CT, 32'h00000001);
    e0 = evt_n;
    repeat (30) @(posedge clk);
    check(32'(evt_n - e0), 32'h00000000);
    tally_and_finish();
  end
endmodule : tb_pct_timer
`default_nettype wire
